/* logic/sss_pkg.sv */
// Purpose: shared constants and types of the status summary block
// Assumes: one clock domain, query port driven by the command decoder
// Notes:   register selects and bit positions are fixed by the status tree
package sss_pkg;

  localparam int REG_W  = 16;
  localparam int BYTE_W = 8;
  localparam int NREG   = 6;

  // registers 0 to 5 held as condition/event/enable triples; ESR and STB are bytes
  typedef enum logic [2:0] {
    SSS_SEL_OPER  = 3'h0,
    SSS_SEL_QUES  = 3'h1,
    SSS_SEL_FREQ  = 3'h2,
    SSS_SEL_LIMIT = 3'h3,
    SSS_SEL_POWER = 3'h4,
    SSS_SEL_SYNC  = 3'h5,
    SSS_SEL_ESR   = 3'h6,
    SSS_SEL_STB   = 3'h7
  } sss_sel_e;

  typedef enum logic [1:0] {
    SSS_OP_COND   = 2'h0,
    SSS_OP_EVENT  = 2'h1,
    SSS_OP_ENA_RD = 2'h2,
    SSS_OP_ENA_WR = 2'h3
  } sss_op_e;

  typedef struct packed {
    logic              valid;
    sss_op_e           op;
    sss_sel_e          sel;
    logic [REG_W-1:0]  data;
  } sss_req_s;

  typedef struct packed {
    logic              valid;
    logic [REG_W-1:0]  data;
  } sss_rsp_s;

  typedef struct packed {
    logic calibration_in_progress;
    logic battery_low;
    logic temperature;
    logic unaligned_label;
    logic ext_reference;
    logic limit1_fail;
    logic limit2_fail;
    logic overload_label;
    logic sync_not_found;
    logic premeas_bounds;
  } sss_cond_s;

  // bit positions
  localparam int OPER_CAL_BIT   = 0;
  localparam int QUES_BATT_BIT  = 2;
  localparam int QUES_TEMP_BIT  = 4;
  localparam int QUES_LIMIT_BIT = 9;
  localparam int QUES_CAL_BIT   = 10;
  localparam int FREQ_EXT_BIT   = 8;
  localparam int LIMIT1_BIT     = 0;
  localparam int LIMIT2_BIT     = 1;
  localparam int POWER_IF_BIT   = 2;
  localparam int SYNC_NF_BIT    = 0;
  localparam int SYNC_PRE_BIT   = 1;
  localparam int STB_ERRQ_BIT   = 2;
  localparam int STB_QUES_BIT   = 3;
  localparam int STB_MAV_BIT    = 4;
  localparam int STB_ESB_BIT    = 5;
  localparam int STB_MSS_BIT    = 6;
  localparam int STB_OPER_BIT   = 7;
  localparam int TOP_BIT        = 15;

  // implemented bits per register; bit 15 never set
  localparam logic [REG_W-1:0] OPER_MASK  = 16'h0001;
  localparam logic [REG_W-1:0] QUES_MASK  = 16'h0614;
  localparam logic [REG_W-1:0] FREQ_MASK  = 16'h0100;
  localparam logic [REG_W-1:0] LIMIT_MASK = 16'h0003;
  localparam logic [REG_W-1:0] POWER_MASK = 16'h0004;
  localparam logic [REG_W-1:0] SYNC_MASK  = 16'h0003;
  localparam logic [BYTE_W-1:0] ESR_MASK  = 8'hbd;
  localparam logic [BYTE_W-1:0] SRQ_MASK  = 8'hbc;

  localparam logic [REG_W-1:0]  REG_RST  = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

endpackage

/* logic/sss_status_summary.sv */
// Purpose: status register tree with event latching and service request
// Assumes: all inputs synchronous to mclk; esr_set is a pulse per event
// Notes:   answers every query except an enable write one cycle after it is taken
//
// How it works
// - operation register has condition and event parts
// - operation bit 0 follows calibration activity
// - bit 15 of every register reads zero
// - questionable bit 2 flags low battery
// - questionable bit 4 flags questionable temperature
// - questionable bit 9 summarises limit violations
// - questionable bit 10 flags unaligned measurement
// - frequency bit 8 flags external reference
// - limit bits 0 and 1 flag lines
// - power bit 2 flags intermediate frequency overload
// - sync register reports sync and premeasurement faults
// - service request from enabled status byte bits
// - status byte bits summarise lower sources
// - enable parts programmable for every register
// - status byte bit 5 from enabled events
// - status byte bit 7 from operation events
`timescale 1ns/1ps
`default_nettype none
module sss_status_summary
  import sss_pkg::*;
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // live instrument state
  input  wire sss_cond_s        cond_in,
  input  wire logic [BYTE_W-1:0] esr_set,
  input  wire logic             err_queue_nonempty,
  input  wire logic             msg_available,
  // query port
  input  wire sss_req_s         req,
  output var  sss_rsp_s         rsp,
  // service request
  output logic                  srq
);

  function automatic logic [REG_W-1:0] reg_mask(input int idx);
    case (idx)
      0:       reg_mask = OPER_MASK;
      1:       reg_mask = QUES_MASK;
      2:       reg_mask = FREQ_MASK;
      3:       reg_mask = LIMIT_MASK;
      4:       reg_mask = POWER_MASK;
      5:       reg_mask = SYNC_MASK;
      default: reg_mask = REG_RST;
    endcase
  endfunction

  logic [REG_W-1:0]  cond  [NREG];
  logic [REG_W-1:0]  prev  [NREG];
  logic [REG_W-1:0]  event_q [NREG];
  logic [REG_W-1:0]  ena   [NREG];
  logic [BYTE_W-1:0] esr;
  logic [BYTE_W-1:0] ese;
  logic [BYTE_W-1:0] sre;
  logic [BYTE_W-1:0] stb;
  logic [REG_W-1:0]  next_rdata;
  logic              event_summary_bit;
  logic              oper_sum;
  logic              ques_sum;
  logic              rd_event;
  logic              wr_ena;

  // live condition parts, unused bits forced low
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      cond[i] = REG_RST;
    end
    cond[0][OPER_CAL_BIT]   = cond_in.calibration_in_progress;
    cond[2][FREQ_EXT_BIT]   = cond_in.ext_reference;
    cond[3][LIMIT1_BIT]     = cond_in.limit1_fail;
    cond[3][LIMIT2_BIT]     = cond_in.limit2_fail;
    cond[4][POWER_IF_BIT]   = cond_in.overload_label;
    cond[5][SYNC_NF_BIT]    = cond_in.sync_not_found;
    cond[5][SYNC_PRE_BIT]   = cond_in.premeas_bounds;
    cond[1][QUES_BATT_BIT]  = cond_in.battery_low;
    cond[1][QUES_TEMP_BIT]  = cond_in.temperature;
    cond[1][QUES_LIMIT_BIT] = |cond[3];
    cond[1][QUES_CAL_BIT]   = cond_in.unaligned_label;
  end

  assign rd_event = req.valid && (req.op == SSS_OP_EVENT);
  assign wr_ena   = req.valid && (req.op == SSS_OP_ENA_WR);

  // previous condition for positive transition detection
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NREG; i++) prev[i] <= REG_RST;
    end else begin
      for (int i = 0; i < NREG; i++) prev[i] <= cond[i];
    end
  end

  // event parts: a new transition wins over a clearing read
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NREG; i++) event_q[i] <= REG_RST;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        event_q[i] <= ((rd_event && req.sel == sss_sel_e'(i)) ?
                       REG_RST : event_q[i])
                      | (cond[i] & ~prev[i] & reg_mask(i));
      end
    end
  end

  // enable parts, masked so unused bits cannot summarise
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NREG; i++) ena[i] <= REG_RST;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        if (wr_ena && req.sel == sss_sel_e'(i)) begin
          ena[i] <= req.data & reg_mask(i);
        end
      end
    end
  end

  // event status register and its enable; read clears, set wins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      esr <= BYTE_RST;
    end else begin
      esr <= ((rd_event && req.sel == SSS_SEL_ESR) ? BYTE_RST : esr)
             | (esr_set & ESR_MASK);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ese <= BYTE_RST;
      sre <= BYTE_RST;
    end else if (wr_ena) begin
      if (req.sel == SSS_SEL_ESR) ese <= req.data[BYTE_W-1:0] & ESR_MASK;
      if (req.sel == SSS_SEL_STB) sre <= req.data[BYTE_W-1:0] & SRQ_MASK;
    end
  end

  // summaries; sub-registers feed the questionable summary directly
  assign event_summary_bit      = |(esr & ese);
  assign oper_sum = |(event_q[0] & ena[0]);
  assign ques_sum = |(event_q[1] & ena[1]) | |(event_q[2] & ena[2])
                    | |(event_q[3] & ena[3]) | |(event_q[4] & ena[4])
                    | |(event_q[5] & ena[5]);

  always_comb begin
    stb               = BYTE_RST;
    stb[STB_ERRQ_BIT] = err_queue_nonempty;
    stb[STB_QUES_BIT] = ques_sum;
    stb[STB_MAV_BIT]  = msg_available;
    stb[STB_ESB_BIT]  = event_summary_bit;
    stb[STB_OPER_BIT] = oper_sum;
    stb[STB_MSS_BIT]  = srq;
  end

  // service request; mask has no bit 6 so it cannot feed itself
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) srq <= 1'b0;
    else       srq <= |(stb & sre & SRQ_MASK);
  end

  // read mux
  always_comb begin
    next_rdata = REG_RST;
    if (req.sel == SSS_SEL_ESR) begin
      case (req.op)
        SSS_OP_EVENT:  next_rdata = {8'h00, esr};
        SSS_OP_ENA_RD: next_rdata = {8'h00, ese};
        default:       next_rdata = REG_RST;
      endcase
    end else if (req.sel == SSS_SEL_STB) begin
      case (req.op)
        SSS_OP_ENA_RD: next_rdata = {8'h00, sre};
        SSS_OP_ENA_WR: next_rdata = REG_RST;
        default:       next_rdata = {8'h00, stb};
      endcase
    end else begin
      case (req.op)
        SSS_OP_COND:   next_rdata = cond[req.sel];
        SSS_OP_EVENT:  next_rdata = event_q[req.sel];
        SSS_OP_ENA_RD: next_rdata = ena[req.sel];
        default:       next_rdata = REG_RST;
      endcase
    end
    next_rdata[TOP_BIT] = 1'b0;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.valid && (req.op != SSS_OP_ENA_WR);
      rsp.data  <= next_rdata;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_top_zero;
    rsp.valid |-> !rsp.data[TOP_BIT];
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("bit 15 read as one");

  property p_cal_cond;
    (req.valid && req.op == SSS_OP_COND && req.sel == SSS_SEL_OPER)
      |=> rsp.valid && rsp.data[OPER_CAL_BIT] == $past(cond_in.calibration_in_progress);
  endproperty
  a_cal_cond: assert property (p_cal_cond)
    else $error("calibration condition wrong");

  property p_oper_event;
    $rose(cond_in.calibration_in_progress) |=> event_q[0][OPER_CAL_BIT];
  endproperty
  a_oper_event: assert property (p_oper_event)
    else $error("operation event not latched");

  property p_read_clear;
    (rd_event && req.sel == SSS_SEL_LIMIT && !$rose(cond_in.limit1_fail)
     && !$rose(cond_in.limit2_fail)) |=> event_q[3] == REG_RST;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("event not cleared by read");

  property p_unused_zero;
    (event_q[2] & ~FREQ_MASK) == REG_RST && (ena[4] & ~POWER_MASK) == REG_RST;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bit set");

  property p_limit_sum;
    (cond_in.limit1_fail || cond_in.limit2_fail) |-> cond[1][QUES_LIMIT_BIT];
  endproperty
  a_limit_sum: assert property (p_limit_sum)
    else $error("limit summary missing");

  property p_overload;
    (req.valid && req.op == SSS_OP_COND && req.sel == SSS_SEL_POWER)
      |=> rsp.data[POWER_IF_BIT] == $past(cond_in.overload_label);
  endproperty
  a_overload: assert property (p_overload)
    else $error("overload bit wrong");

  property p_srq_esb;
    (event_summary_bit && sre[STB_ESB_BIT]) |=> srq;
  endproperty
  a_srq_esb: assert property (p_srq_esb)
    else $error("service request missing");

  property p_srq_cause;
    srq |-> $past(|(stb & sre));
  endproperty
  a_srq_cause: assert property (p_srq_cause)
    else $error("service request without cause");

  property p_oper_sum;
    (event_q[0][OPER_CAL_BIT] && ena[0][OPER_CAL_BIT]) |-> stb[STB_OPER_BIT];
  endproperty
  a_oper_sum: assert property (p_oper_sum)
    else $error("operation summary missing");

  property p_batt_low;
    (req.valid && req.op == SSS_OP_COND && req.sel == SSS_SEL_QUES)
      |=> rsp.data[QUES_BATT_BIT] == $past(cond_in.battery_low);
  endproperty
  a_batt_low: assert property (p_batt_low)
    else $error("battery low bit wrong");

  property p_temperature;
    (req.valid && req.op == SSS_OP_COND && req.sel == SSS_SEL_QUES)
      |=> rsp.data[QUES_TEMP_BIT] == $past(cond_in.temperature);
  endproperty
  a_temperature: assert property (p_temperature)
    else $error("temperature bit wrong");

  property p_unaligned;
    (req.valid && req.op == SSS_OP_COND && req.sel == SSS_SEL_QUES)
      |=> rsp.data[QUES_CAL_BIT] == $past(cond_in.unaligned_label);
  endproperty
  a_unaligned: assert property (p_unaligned)
    else $error("unaligned bit wrong");

  property p_ext_ref;
    (req.valid && req.op == SSS_OP_COND && req.sel == SSS_SEL_FREQ)
      |=> rsp.data[FREQ_EXT_BIT] == $past(cond_in.ext_reference)
          && (rsp.data & ~FREQ_MASK) == REG_RST;
  endproperty
  a_ext_ref: assert property (p_ext_ref)
    else $error("reference bit wrong");

  property p_limit_lines;
    (req.valid && req.op == SSS_OP_COND && req.sel == SSS_SEL_LIMIT)
      |=> rsp.data[LIMIT1_BIT] == $past(cond_in.limit1_fail)
          && rsp.data[LIMIT2_BIT] == $past(cond_in.limit2_fail);
  endproperty
  a_limit_lines: assert property (p_limit_lines)
    else $error("limit line bits wrong");

  property p_sync_event;
    $rose(cond_in.sync_not_found) |=> event_q[5][SYNC_NF_BIT];
  endproperty
  a_sync_event: assert property (p_sync_event)
    else $error("sync event not latched");

  property p_ques_sum;
    (|(event_q[1] & ena[1])) |-> stb[STB_QUES_BIT];
  endproperty
  a_ques_sum: assert property (p_ques_sum)
    else $error("questionable summary missing");

  property p_ena_write;
    (wr_ena && req.sel == SSS_SEL_OPER)
      |=> ena[0] == ($past(req.data) & OPER_MASK);
  endproperty
  a_ena_write: assert property (p_ena_write)
    else $error("operation enable not written");

  property p_esb_bit;
    (|(esr_set & ese) && !(wr_ena && req.sel == SSS_SEL_ESR))
      |=> stb[STB_ESB_BIT];
  endproperty
  a_esb_bit: assert property (p_esb_bit)
    else $error("event summary bit missing");

  property p_srq_drop;
    !(|(stb & sre)) |=> !srq;
  endproperty
  a_srq_drop: assert property (p_srq_drop)
    else $error("service request without enabled bit");

  property p_event_hold;
    (event_q[3][LIMIT1_BIT] && !(rd_event && req.sel == SSS_SEL_LIMIT))
      |=> event_q[3][LIMIT1_BIT];
  endproperty
  a_event_hold: assert property (p_event_hold)
    else $error("event lost without a read");

  property p_esr_clear;
    (rd_event && req.sel == SSS_SEL_ESR && esr_set == BYTE_RST)
      |=> esr == BYTE_RST;
  endproperty
  a_esr_clear: assert property (p_esr_clear)
    else $error("event status not cleared by read");

  property p_write_silent;
    (req.valid && req.op == SSS_OP_ENA_WR) |=> !rsp.valid;
  endproperty
  a_write_silent: assert property (p_write_silent)
    else $error("answer to an enable write");

endmodule
`default_nettype wire

/* verification/sss_ctrl_model.sv */
// Purpose: remote controller issuing status queries and mask writes
// Assumes: requests launched 1 ns after a rising edge
// Notes:   idle request data is scrambled so stale words never match
`timescale 1ns/1ps
`default_nettype none
module sss_ctrl_model
  import sss_pkg::*;
(
  // clock
  input  wire logic     mclk,
  // query port
  output var  sss_req_s req,
  input  wire sss_rsp_s rsp
);
  initial req = '0;

  // answer registered on the taking edge, read once it has settled
  task automatic xfer(input sss_op_e op, input sss_sel_e sel,
                      input logic [REG_W-1:0] d,
                      output logic [REG_W-1:0] q);
    req = '{1'b1, op, sel, d};
    @(posedge mclk);
    #1;
    q = rsp.valid ? rsp.data : 'x;
    req = '{1'b0, op, sel, ~d};
    // one idle edge, so the next call never re-raises valid in this step
    @(posedge mclk);
    #1;
  endtask

  // full masks so every source can reach a service request
  task automatic enable_all();
    logic [REG_W-1:0] q;
    for (int s = 0; s < 8; s++) begin
      xfer(SSS_OP_ENA_WR, sss_sel_e'(s), 16'hffff, q);
    end
  endtask
endmodule
`default_nettype wire

/* verification/test_scpi_status_summary.sv */
// Purpose: self-checking bench of the status summary block
// Assumes: controller model drives the query port
// Notes:   seed fixed at 55 so runs repeat
`timescale 1ns/1ps
`default_nettype none
module test_scpi_status_summary;
  import sss_pkg::*;
  logic             mclk = 1'b0;
  logic             nrst = 1'b0;
  sss_cond_s        cond_in = '0;
  logic [7:0]       esr_set = 8'h00;
  logic             err_queue_nonempty = 1'b0;
  logic             msg_available = 1'b0;
  sss_req_s         req;
  sss_rsp_s         rsp;
  logic             srq;
  int               error_cnt = 0;
  int               checks_done = 0;
  int               seed = 55;
  int               cyc = 0;
  logic [15:0]      ena_exp [8] = '{16'h0001, 16'h0614, 16'h0100, 16'h0003,
                                    16'h0004, 16'h0003, 16'h00bd, 16'h00bc};
  int               srq_bit [5] = '{2, 3, 4, 5, 7};

  initial forever #20 mclk = ~mclk;

  sss_status_summary i_dut (.mclk(mclk), .nrst(nrst), .cond_in(cond_in),
    .esr_set(esr_set), .err_queue_nonempty(err_queue_nonempty),
    .msg_available(msg_available), .req(req), .rsp(rsp), .srq(srq));
  sss_ctrl_model i_ctrl (.mclk(mclk), .req(req), .rsp(rsp));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  task automatic do_reset();
    nrst = 1'b0;
    cond_in = '0;
    err_queue_nonempty = 1'b0;
    msg_available = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    nrst = 1'b1;
  endtask

  function automatic logic [15:0] exp_cond(int s, sss_cond_s c);
    logic [15:0] v;
    v = '0;
    case (s)
      0: v[0] = c.calibration_in_progress;
      1: begin
        v[2] = c.battery_low;
        v[4] = c.temperature;
        v[9] = c.limit1_fail | c.limit2_fail;
        v[10] = c.unaligned_label;
      end
      2: v[8] = c.ext_reference;
      3: v[1:0] = {c.limit2_fail, c.limit1_fail};
      4: v[2] = c.overload_label;
      5: v[1:0] = {c.premeas_bounds, c.sync_not_found};
      default: v = '0;
    endcase
    return v;
  endfunction

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    logic [15:0] q;
    sss_cond_s   c;
    do_reset();
    for (int s = 0; s < 8; s++) begin
      i_ctrl.xfer(SSS_OP_ENA_RD, sss_sel_e'(s), 16'($random(seed)), q);
      check(q, 16'h0000);
    end
    $display("test reset done");
    repeat (40) begin
      c = sss_cond_s'(10'($random(seed)));
      cond_in = c;
      for (int s = 0; s < 6; s++) begin
        i_ctrl.xfer(SSS_OP_COND, sss_sel_e'(s), 16'($random(seed)), q);
        check(q, exp_cond(s, c));
      end
    end
    $display("test conditions done");
    // a rise latches once; a second read must find it cleared
    do_reset();
    c = sss_cond_s'(10'($random(seed)));
    c.calibration_in_progress = 1'b1;
    cond_in = c;
    esr_set = 8'hff;
    step();
    esr_set = 8'h00;
    step();
    for (int s = 0; s < 6; s++) begin
      i_ctrl.xfer(SSS_OP_EVENT, sss_sel_e'(s), 16'h0000, q);
      check(q, exp_cond(s, c));
      i_ctrl.xfer(SSS_OP_EVENT, sss_sel_e'(s), 16'h0000, q);
      check(q, 16'h0000);
      i_ctrl.xfer(SSS_OP_COND, sss_sel_e'(s), 16'h0000, q);
      check(q, exp_cond(s, c));
    end
    i_ctrl.xfer(SSS_OP_EVENT, SSS_SEL_ESR, 16'h0000, q);
    check(q, 16'h00bd);
    i_ctrl.enable_all();
    for (int s = 0; s < 8; s++) begin
      i_ctrl.xfer(SSS_OP_ENA_RD, sss_sel_e'(s), 16'h0000, q);
      check(q, ena_exp[s]);
    end
    $display("test events and enables done");
    // each status byte source alone behind a one-bit request mask
    foreach (srq_bit[k]) begin
      do_reset();
      i_ctrl.enable_all();
      i_ctrl.xfer(SSS_OP_ENA_WR, SSS_SEL_STB, 16'h1 << srq_bit[k], q);
      repeat (3) step();
      check({15'h0, srq}, 16'h0000);
      case (srq_bit[k])
        2: err_queue_nonempty = 1'b1;
        3: cond_in.temperature = 1'b1;
        4: msg_available = 1'b1;
        5: esr_set = 8'h01;
        default: cond_in.calibration_in_progress = 1'b1;
      endcase
      step();
      esr_set = 8'h00;
      repeat (3) step();
      check({15'h0, srq}, 16'h0001);
      i_ctrl.xfer(SSS_OP_COND, SSS_SEL_STB, 16'h0000, q);
      check(q & 16'h00bc, 16'h1 << srq_bit[k]);
      i_ctrl.xfer(SSS_OP_ENA_WR, SSS_SEL_STB, 16'h0000, q);
      repeat (3) step();
      check({15'h0, srq}, 16'h0000);
    end
    $display("test service request done");
    test_done();
  end
endmodule
`default_nettype wire
